// ==== hdl/cfpd_pkg.sv ====
// Constants, pin bundle and state types for the configuration port block
package cfpd_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLEAR_TIME_NS = 1000;
  localparam int CLEAR_CYCLES =
    (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_TICK_NS = 320;
  localparam int WAKE_TICK_CYCLES = WAKE_TICK_NS / CLK_PERIOD_NS;
  localparam int WAKE_STEPS = 4;
  localparam int CNT_W = 8;

  // ==========================================================
  // Widths and codes
  localparam int DATA_W = 8;
  localparam int RB_DEPTH = 16;
  localparam int RB_AW = 4;
  localparam int IR_W = 8;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 8'h01;
  localparam logic [IR_W-1:0] IR_BYPASS_CODE = 8'hff;
  localparam logic [IR_W-1:0] IR_ISC_DISABLE_CODE = 8'h1e;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // ==========================================================
  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic progReqN;
    logic portModeSel;
    logic configByteClock;
    logic selectN;
    logic readReq;
    logic initIn;
    logic doneIn;
    logic testClk;
    logic testModeSel;
    logic testDataIn;
    logic [DATA_W-1:0] data;
  } cfpd_pins_t;

  // Idle levels: request, select and init lines rest high
  localparam cfpd_pins_t PINS_RST = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0,
    1'b1, 1'b0, 1'b0, 1'b1, 1'b1, DATA_RST};

  // ==========================================================
  // State machines
  typedef enum logic [2:0] {
    CFG_USER, CFG_CLEAR, CFG_INIT_WAIT, CFG_LOAD, CFG_ERROR,
    CFG_RB_WAIT, CFG_RB_XFER
  } cfpd_cfg_state_t;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
    TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } cfpd_tap_state_t;

  // Standard test-port controller transitions
  function automatic cfpd_tap_state_t cfpd_tap_next(
      cfpd_tap_state_t s, logic tms);
    cfpd_tap_state_t n;
    n = TAP_RESET;
    case (s)
      TAP_RESET: n = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: n = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: n = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: n = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: n = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: n = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: n = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: n = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: n = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: n = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: n = tms ? TAP_SEL_DR : TAP_IDLE;
      default: n = TAP_RESET;
    endcase
    return n;
  endfunction : cfpd_tap_next

endpackage : cfpd_pkg

// ==== hdl/cfpd_readback_mem.sv ====
// Small readback byte store with registered read data
module cfpd_readback_mem
  import cfpd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [RB_AW-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic rdEn,
  input wire logic [RB_AW-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);

  // ==========================================================
  // Storage
  logic [DATA_W-1:0] mem [RB_DEPTH];

  // Array left unreset so it maps onto plain RAM
  always_ff @(posedge clock) begin
    if (clkEn && wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Read data always leaves through a register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdData <= DATA_RST;
    end else if (clkEn && rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule : cfpd_readback_mem

// ==== hdl/cfpd_config_port.sv ====
// Byte-wide configuration port, test-port control and completion flags
//
// Contract
// - Keep setting holds pins in configuration role
// - Without keep, pins are user I/O idle
// - Low reconfig request reclaims pins in port mode
// - Byte clock honoured only while select low
// - Wake-up paced by byte clock or internal
// - Data bus active only while select low
// - Readback high makes data bus outputs
// - Init pulled low at start, released when ready
// - Init held low while reconfig request low in port mode
// - Loading waits until init line reads high
// - Init driven low on CRC failure
// - Readback rise enters readback wait state
// - Readback bytes start on next clock rise
// - Test controller moves on test clock fall
// - Test output released unless shifting
// - No test reset input exists
// - Two flags; volatile clear forces scan, done low
// - Disable instruction sets volatile flag in test mode, nvTarget low
// - Volatile flag set after CRC passes
// - Refresh copies nonvolatile flag to volatile
// - Nonvolatile flag set only by verified disable
// - Done pin open-drain, host may hold low
module cfpd_config_port
  import cfpd_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic keepConfigPins,
  input wire logic wakeUseByteClock,
  input wire logic progReqN,
  input wire logic portModeSel,
  input wire logic configByteClock,
  input wire logic selectN,
  input wire logic readReq,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOeN,
  input wire logic initIn,
  output logic initOut,
  output logic initOeN,
  input wire logic doneIn,
  output logic doneOut,
  output logic doneOeN,
  input wire logic testClk,
  input wire logic testModeSel,
  input wire logic testDataIn,
  output logic testDataOut,
  output logic testDataOeN,
  input wire logic crcCheckDone,
  input wire logic crcCheckPass,
  input wire logic nvTarget,
  input wire logic nvProgVerified,
  input wire logic rbWrEn,
  input wire logic [RB_AW-1:0] rbWrAddr,
  input wire logic [DATA_W-1:0] rbWrData,
  output logic [DATA_W-1:0] cfgByte,
  output logic cfgByteValid,
  output logic cfgPinsActive,
  output logic ioFromScan,
  output logic volatileComplete,
  output logic nonvolatileComplete,
  output logic wakeComplete
);

  // ==========================================================
  // Pin synchronisers and edge detection
  cfpd_pins_t pinsIn;
  cfpd_pins_t sync1Q;
  cfpd_pins_t sync2Q;
  cfpd_pins_t prevQ;

  assign pinsIn = '{progReqN, portModeSel, configByteClock, selectN,
    readReq, initIn, doneIn, testClk, testModeSel, testDataIn, dataIn};

  // Two stages before anything looks at a pin
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1Q <= PINS_RST;
      sync2Q <= PINS_RST;
      prevQ <= PINS_RST;
    end else if (clkEn) begin
      sync1Q <= pinsIn;
      sync2Q <= sync1Q;
      prevQ <= sync2Q;
    end
  end

  logic byteClkRise;
  logic progFall;
  logic progRise;
  logic readRise;
  logic testRise;
  logic testFall;

  // Byte clock counts only with select low
  assign byteClkRise = sync2Q.configByteClock & ~prevQ.configByteClock
    & ~sync2Q.selectN;
  assign progFall = prevQ.progReqN & ~sync2Q.progReqN;
  assign progRise = ~prevQ.progReqN & sync2Q.progReqN;
  assign readRise = sync2Q.readReq & ~prevQ.readReq;
  assign testRise = sync2Q.testClk & ~prevQ.testClk;
  assign testFall = ~sync2Q.testClk & prevQ.testClk;

  // ==========================================================
  // Configuration sequencer
  cfpd_cfg_state_t cfgStateQ;
  logic [CNT_W-1:0] clearCntQ;
  logic powerUpQ;
  logic startCfg;
  logic byteModeQ;

  // Power-up acts like a request once the first enabled cycle arrives
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      powerUpQ <= 1'b1;
    end else if (clkEn) begin
      powerUpQ <= 1'b0;
    end
  end

  // Mode strap is only trusted once synchronised
  assign startCfg = (progFall | powerUpQ) & ~sync2Q.portModeSel;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfgStateQ <= CFG_USER;
      clearCntQ <= '0;
    end else if (clkEn) begin
      if (startCfg) begin
        cfgStateQ <= CFG_CLEAR;
        clearCntQ <= '0;
      end else begin
        case (cfgStateQ)
          CFG_USER: begin
            if (readRise && cfgPinsActive && sync2Q.readReq) begin
              cfgStateQ <= CFG_RB_WAIT;
            end
          end
          CFG_CLEAR: begin
            // Clearing cannot finish while the request is held low
            if (!sync2Q.progReqN) begin
              clearCntQ <= '0;
            end else if (clearCntQ == CNT_W'(CLEAR_CYCLES - 1)) begin
              cfgStateQ <= CFG_INIT_WAIT;
            end else begin
              clearCntQ <= clearCntQ + 1'b1;
            end
          end
          CFG_INIT_WAIT: begin
            // Host may keep the line low to postpone loading
            if (sync2Q.initIn) begin
              cfgStateQ <= CFG_LOAD;
            end
          end
          CFG_LOAD: begin
            if (crcCheckDone) begin
              cfgStateQ <= crcCheckPass ? CFG_USER : CFG_ERROR;
            end
          end
          CFG_ERROR: begin
            cfgStateQ <= CFG_ERROR; // left only by a new request
          end
          CFG_RB_WAIT: begin
            if (!sync2Q.readReq) begin
              cfgStateQ <= CFG_USER;
            end else if (!sync2Q.selectN) begin
              cfgStateQ <= CFG_RB_XFER;
            end
          end
          CFG_RB_XFER: begin
            if (!sync2Q.readReq) begin
              cfgStateQ <= CFG_USER;
            end
          end
          default: cfgStateQ <= CFG_USER;
        endcase
      end
    end
  end

  // ==========================================================
  // Pin role and bus direction
  logic cfgBusy;
  assign cfgBusy = (cfgStateQ == CFG_CLEAR) | (cfgStateQ == CFG_INIT_WAIT)
    | (cfgStateQ == CFG_LOAD) | (cfgStateQ == CFG_ERROR);

  // Keep setting wins; otherwise pins are only borrowed while busy
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfgPinsActive <= 1'b1;
    end else if (clkEn) begin
      cfgPinsActive <= keepConfigPins
        | cfgBusy
        | (~sync2Q.portModeSel & ~sync2Q.progReqN);
    end
  end

  // Drive only when selected and reading back
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dataOeN <= 1'b1;
    end else if (clkEn) begin
      dataOeN <= ~(cfgPinsActive & ~sync2Q.selectN
        & sync2Q.readReq);
    end
  end

  // ==========================================================
  // Configuration byte capture
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfgByte <= DATA_RST;
      cfgByteValid <= 1'b0;
    end else if (clkEn) begin
      cfgByteValid <= 1'b0;
      if (cfgStateQ == CFG_LOAD && byteClkRise && !sync2Q.readReq) begin
        cfgByte <= sync2Q.data;
        cfgByteValid <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Readback path
  logic [RB_AW-1:0] rbAddrQ;
  logic rbRdEn;
  logic rbLoadQ;
  logic [DATA_W-1:0] rbRdData;

  assign rbRdEn = (cfgStateQ == CFG_RB_XFER) & byteClkRise;

  // Address restarts every time a readback begins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rbAddrQ <= '0;
      rbLoadQ <= 1'b0;
    end else if (clkEn) begin
      rbLoadQ <= rbRdEn;
      if (cfgStateQ == CFG_RB_WAIT) begin
        rbAddrQ <= '0;
      end else if (rbRdEn) begin
        rbAddrQ <= rbAddrQ + 1'b1;
      end
    end
  end

  cfpd_readback_mem u_rbMem (
    .clock(clock),
    .rstn(rstn),
    .clkEn(clkEn),
    .wrEn(rbWrEn),
    .wrAddr(rbWrAddr),
    .wrData(rbWrData),
    .rdEn(rbRdEn),
    .rdAddr(rbAddrQ),
    .rdData(rbRdData)
  );

  // One byte per transfer onto the pins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dataOut <= DATA_RST;
    end else if (clkEn && rbLoadQ) begin
      dataOut <= rbRdData;
    end
  end

  // ==========================================================
  // Test-port controller; no reset pin, TMS high five falls resets
  cfpd_tap_state_t tapStateQ;
  logic [IR_W-1:0] irShiftQ;
  logic bypassQ;
  logic iscDisable;
  cfpd_tap_state_t tapNext;

  assign tapNext = cfpd_tap_next(tapStateQ, sync2Q.testModeSel);

  // Stopped clock at either level simply produces no edges
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tapStateQ <= TAP_RESET;
    end else if (clkEn && testFall) begin
      tapStateQ <= tapNext;
    end
  end

  // Data paths shift on the opposite edge from state moves
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irShiftQ <= IR_BYPASS_CODE;
      bypassQ <= 1'b0;
    end else if (clkEn && testRise) begin
      case (tapStateQ)
        TAP_RESET: irShiftQ <= IR_BYPASS_CODE;
        TAP_CAP_IR: irShiftQ <= IR_CAPTURE_VAL;
        TAP_SHIFT_IR: irShiftQ <= {sync2Q.testDataIn, irShiftQ[IR_W-1:1]};
        TAP_CAP_DR: bypassQ <= 1'b0;
        TAP_SHIFT_DR: bypassQ <= sync2Q.testDataIn;
        default: bypassQ <= bypassQ;
      endcase
    end
  end

  assign iscDisable = clkEn & testFall & (tapStateQ == TAP_UPD_IR)
    & (irShiftQ == IR_ISC_DISABLE_CODE);

  // Follows the state entered, so the first captured bit leads
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      testDataOut <= 1'b0;
      testDataOeN <= 1'b1;
    end else if (clkEn && testFall) begin
      testDataOut <= (tapNext == TAP_SHIFT_IR) ? irShiftQ[0] : bypassQ;
      testDataOeN <= ~((tapNext == TAP_SHIFT_IR)
        | (tapNext == TAP_SHIFT_DR));
    end
  end

  // ==========================================================
  // Completion flags
  logic crcPass;
  assign crcPass = (cfgStateQ == CFG_LOAD) & crcCheckDone & crcCheckPass;

  // Clear first, sets after, so a same-cycle set beats a clear; the refresh copy comes last and wins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      volatileComplete <= 1'b0;
    end else if (clkEn) begin
      if (progFall || startCfg) begin
        volatileComplete <= 1'b0;
      end
      if (crcPass) begin
        volatileComplete <= 1'b1;
      end
      if (iscDisable && sync2Q.portModeSel && !nvTarget) begin
        volatileComplete <= 1'b1;
      end
      if (progRise && sync2Q.portModeSel) begin
        volatileComplete <= nonvolatileComplete;
      end
    end
  end

  // Never touches the done pin; only reaches it through refresh
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      nonvolatileComplete <= 1'b0;
    end else if (clkEn && iscDisable && nvTarget && nvProgVerified) begin
      nonvolatileComplete <= 1'b1;
    end
  end

  // ==========================================================
  // Open-drain pins; value held low, enable low pulls the line
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      initOut <= 1'b0;
      initOeN <= 1'b1;
      doneOut <= 1'b0;
      doneOeN <= 1'b0;
      ioFromScan <= 1'b1;
    end else if (clkEn) begin
      initOut <= 1'b0;
      doneOut <= 1'b0;
      initOeN <= ~((cfgStateQ == CFG_CLEAR)
        | (~sync2Q.portModeSel & ~sync2Q.progReqN)
        | (cfgStateQ == CFG_ERROR));
      doneOeN <= volatileComplete;
      ioFromScan <= ~volatileComplete;
    end
  end

  // ==========================================================
  // Wake-up sequencer
  logic [CNT_W-1:0] tickCntQ;
  logic [CNT_W-1:0] wakeCntQ;
  logic intTick;
  logic wakeTick;

  // Internal pacing tick, free running
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tickCntQ <= '0;
    end else if (clkEn) begin
      if (tickCntQ == CNT_W'(WAKE_TICK_CYCLES - 1)) begin
        tickCntQ <= '0;
      end else begin
        tickCntQ <= tickCntQ + 1'b1;
      end
    end
  end

  assign intTick = tickCntQ == CNT_W'(WAKE_TICK_CYCLES - 1);
  assign wakeTick = wakeUseByteClock ? byteClkRise : intTick;

  // Host holding done low stalls the sequence
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wakeCntQ <= '0;
      wakeComplete <= 1'b0;
    end else if (clkEn) begin
      if (!volatileComplete) begin
        wakeCntQ <= '0;
        wakeComplete <= 1'b0;
      end else if (sync2Q.doneIn && wakeTick && !wakeComplete) begin
        if (wakeCntQ == CNT_W'(WAKE_STEPS - 1)) begin
          wakeComplete <= 1'b1;
        end else begin
          wakeCntQ <= wakeCntQ + 1'b1;
        end
      end
    end
  end

endmodule : cfpd_config_port

// ==== testbench/cfpd_config_port_asserts.sv ====
// Concurrent checks on the configuration port pins and flags
module cfpd_asserts (
  input wire logic clock,
  input wire logic rstn,
  input wire logic portModeSel,
  input wire logic selectN,
  input wire logic readReq,
  input wire logic progReqN,
  input wire logic crcCheckDone,
  input wire logic crcCheckPass,
  input wire logic nvTarget,
  input wire logic nvProgVerified,
  input wire logic dataOeN,
  input wire logic initOeN,
  input wire logic doneOeN,
  input wire logic cfgByteValid,
  input wire logic cfgPinsActive,
  input wire logic ioFromScan,
  input wire logic volatileComplete,
  input wire logic nonvolatileComplete
);
  // ==========================================================
  // Checks, all on the system clock
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Flag copies may trail by an edge, so judge them once settled
  scan_io_a: assert property ($stable(volatileComplete) |->
    ioFromScan == !volatileComplete) else $error("scan control wrong");
  done_pin_a: assert property ($stable(volatileComplete) |->
    doneOeN == volatileComplete) else $error("done pin wrong");
  // Pins pass a two-flop synchroniser, hence the run lengths
  bus_idle_a: assert property (selectN [*5] |-> dataOeN)
    else $error("bus driven while deselected");
  bus_in_a: assert property (!readReq [*5] |-> dataOeN)
    else $error("bus driven while writing");
  bus_out_a: assert property (
    (readReq && !selectN && cfgPinsActive) [*5] |-> !dataOeN)
    else $error("readback bus not driven");
  byte_sel_a: assert property (selectN [*7] |-> !cfgByteValid)
    else $error("byte taken while deselected");
  byte_pulse_a: assert property (cfgByteValid |=> !cfgByteValid)
    else $error("byte valid too long");
  crc_set_a: assert property (
    $rose(volatileComplete) && !portModeSel |->
    $past(crcCheckDone && crcCheckPass)) else $error("flag set, no CRC");
  crc_fail_a: assert property (
    crcCheckDone && !crcCheckPass && initOeN && !volatileComplete &&
    !portModeSel |-> ##[1:3] !initOeN) else $error("CRC fail unflagged");
  init_hold_a: assert property (
    (!progReqN && !portModeSel) [*5] |-> !initOeN)
    else $error("init released during request");
  nv_set_a: assert property ($rose(nonvolatileComplete) |->
    $past(nvTarget && nvProgVerified)) else $error("nonvolatile set early");
endmodule : cfpd_asserts

bind cfpd_config_port cfpd_asserts cfpd_asserts_i (.clock, .rstn,
  .portModeSel, .selectN, .readReq, .progReqN, .crcCheckDone,
  .crcCheckPass, .nvTarget, .nvProgVerified, .dataOeN, .initOeN, .doneOeN,
  .cfgByteValid, .cfgPinsActive, .ioFromScan, .volatileComplete,
  .nonvolatileComplete);

// ==== testbench/cfpd_host.sv ====
// Host model: drives the port pins and resolves the shared lines
module cfpd_host
  import cfpd_pkg::*;
(
  input wire logic clock,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic dataOeN,
  input wire logic initOut,
  input wire logic initOeN,
  input wire logic doneOut,
  input wire logic doneOeN,
  output cfpd_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Host levels; init held at power-up to postpone loading
  cfpd_pins_t drv = PINS_RST;
  logic initHold = 1'b1;
  logic doneHold = 1'b0;
  logic dataDrv = 1'b1;

  // Open-drain lines pulled up; a released bus never keeps its value
  always_comb begin
    pins = drv;
    pins.initIn = (initOeN | initOut) & ~initHold;
    pins.doneIn = (doneOeN | doneOut) & ~doneHold;
    pins.data = !dataOeN ? dataOut : dataDrv ? drv.data : ~drv.data;
  end

  // ==========================================================
  // Transfers
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // One byte-clock period of 320 ns, data held around the rise
  task automatic byte_clk(input logic [7:0] b, output logic [7:0] q);
    drv.data <= b;
    tick(3);
    drv.configByteClock <= 1'b1;
    tick(4);
    drv.configByteClock <= 1'b0;
    tick(1);
    q = pins.data;
  endtask : byte_clk

  // Test clock rests low between calls, mode held across the fall
  task automatic tap_clk(input logic tms, input logic tdi);
    drv.testModeSel <= tms;
    drv.testDataIn <= tdi;
    tick(4);
    drv.testClk <= 1'b1;
    tick(8);
    drv.testClk <= 1'b0;
    tick(8);
  endtask : tap_clk
endmodule : cfpd_host

// ==== testbench/cfpd_config_port_bench.sv ====
// Self-checking bench for the configuration port block
module cfpd_config_port_bench;
  import cfpd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Design signals and bookkeeping
  logic clock, rstn, keepConfigPins, wakeUseByteClock;
  logic crcCheckDone, crcCheckPass, nvTarget, nvProgVerified, rbWrEn;
  logic [RB_AW-1:0] rbWrAddr;
  logic [DATA_W-1:0] rbWrData, dataOut, cfgByte, q;
  logic dataOeN, initOut, initOeN, doneOut, doneOeN, testDataOut;
  logic testDataOeN, cfgByteValid, cfgPinsActive, ioFromScan;
  logic volatileComplete, nonvolatileComplete, wakeComplete;
  cfpd_pins_t pins;
  int mismatches, cmpCount, nBytes, cycles;

  cfpd_host cfpd_host_i (.clock, .dataOut, .dataOeN, .initOut, .initOeN,
    .doneOut, .doneOeN, .pins);
  cfpd_config_port cfpd_config_port_i (.clock, .rstn, .clkEn(1'b1),
    .keepConfigPins, .wakeUseByteClock, .progReqN(pins.progReqN),
    .portModeSel(pins.portModeSel), .configByteClock(pins.configByteClock),
    .selectN(pins.selectN), .readReq(pins.readReq), .dataIn(pins.data),
    .dataOut, .dataOeN, .initIn(pins.initIn), .initOut, .initOeN,
    .doneIn(pins.doneIn), .doneOut, .doneOeN, .testClk(pins.testClk),
    .testModeSel(pins.testModeSel), .testDataIn(pins.testDataIn),
    .testDataOut, .testDataOeN, .crcCheckDone, .crcCheckPass, .nvTarget,
    .nvProgVerified, .rbWrEn, .rbWrAddr, .rbWrData, .cfgByte,
    .cfgByteValid, .cfgPinsActive, .ioFromScan, .volatileComplete,
    .nonvolatileComplete, .wakeComplete);

  // 25 MHz system clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Count accepted bytes; guard against a hang (run needs ~1400)
  always @(posedge clock) begin
    if (cfgByteValid === 1'b1) nBytes++;
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      finish_test();
    end
  end

  // ==========================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] s);
    cmpCount++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic finish_test();
    $display("Mismatches %0d in %0d comparisons", mismatches, cmpCount);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // Verdict pulse from the stream checker
  task automatic crc(input logic pass);
    crcCheckPass <= pass;
    crcCheckDone <= 1'b1;
    tick(1);
    crcCheckDone <= 1'b0;
    tick(3);
  endtask : crc

  // Idle to instruction shift, load LSB first, update, back to idle
  task automatic tap_ir(input logic [IR_W-1:0] ir);
    for (int i = 0; i < 4; i++) cfpd_host_i.tap_clk(i < 2, 1'b1);
    chk("testDataOut", IR_CAPTURE_VAL[0], testDataOut);
    for (int i = 0; i < IR_W; i++) begin
      cfpd_host_i.tap_clk(i == IR_W - 1, ir[i]);
      if (i == 0) chk("testDataOeN", 0, testDataOeN);
    end
    cfpd_host_i.tap_clk(1'b1, 1'b1);
    cfpd_host_i.tap_clk(1'b0, 1'b1);
    chk("testDataOeN", 1, testDataOeN);
  endtask : tap_ir

  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    keepConfigPins = 1'b1;
    wakeUseByteClock = 1'b1;
    {crcCheckDone, crcCheckPass, nvTarget, nvProgVerified, rbWrEn} = '0;
    rbWrAddr = '0;
    rbWrData = '0;
    tick(12);
    chk("doneOeN", 0, doneOeN);
    chk("dataOeN", 1, dataOeN);
    rstn <= 1'b1;
    // Power-up load; host holds init so the first byte is dropped
    tick(20);
    chk("initOeN", 0, initOeN);
    tick(15);
    chk("initOeN", 1, initOeN);
    cfpd_host_i.drv.selectN <= 1'b0;
    cfpd_host_i.byte_clk(8'h5a, q);
    chk("nBytes", 0, nBytes);
    cfpd_host_i.initHold <= 1'b0;
    tick(4);
    cfpd_host_i.byte_clk(8'ha5, q);
    cfpd_host_i.byte_clk(8'h3c, q);
    chk("cfgByte", 8'h3c, cfgByte);
    cfpd_host_i.drv.selectN <= 1'b1;
    tick(8);
    cfpd_host_i.byte_clk(8'hff, q);
    chk("nBytes", 2, nBytes);
    cfpd_host_i.drv.selectN <= 1'b0;
    crc(1'b1);
    chk("volatileComplete", 1, volatileComplete);
    chk("ioFromScan", 0, ioFromScan);
    // Wake paced by byte-clock rises: three are not enough
    repeat (3) cfpd_host_i.byte_clk(8'h00, q);
    chk("wakeComplete", 0, wakeComplete);
    cfpd_host_i.byte_clk(8'h00, q);
    chk("wakeComplete", 1, wakeComplete);
    // Without persistence the pins turn to user I/O until a request
    keepConfigPins <= 1'b0;
    tick(4);
    chk("cfgPinsActive", 0, cfgPinsActive);
    cfpd_host_i.drv.progReqN <= 1'b0;
    tick(30);
    chk("cfgPinsActive", 1, cfgPinsActive);
    chk("initOeN", 0, initOeN);
    chk("volatileComplete", 0, volatileComplete);
    cfpd_host_i.drv.progReqN <= 1'b1;
    tick(40);
    cfpd_host_i.byte_clk(8'h96, q);
    chk("cfgByte", 8'h96, cfgByte);
    crc(1'b0);
    chk("initOeN", 0, initOeN);
    chk("volatileComplete", 0, volatileComplete);
    // Reload with internal wake while the host holds done low
    wakeUseByteClock <= 1'b0;
    cfpd_host_i.doneHold <= 1'b1;
    cfpd_host_i.drv.progReqN <= 1'b0;
    tick(8);
    cfpd_host_i.drv.progReqN <= 1'b1;
    tick(40);
    crc(1'b1);
    tick(60);
    chk("wakeComplete", 0, wakeComplete);
    cfpd_host_i.doneHold <= 1'b0;
    tick(45);
    chk("wakeComplete", 1, wakeComplete);
    // Persistent pins: write three bytes to the store, then read them over the bus
    keepConfigPins <= 1'b1;
    cfpd_host_i.drv.selectN <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rbWrEn <= 1'b1;
      rbWrAddr <= RB_AW'(i);
      rbWrData <= 8'h21 + 8'(i) * 8'h11;
      tick(1);
    end
    rbWrEn <= 1'b0;
    cfpd_host_i.drv.readReq <= 1'b1;
    cfpd_host_i.dataDrv <= 1'b0;
    tick(6);
    chk("cfgPinsActive", 1, cfgPinsActive);
    chk("dataOeN", 1, dataOeN);
    cfpd_host_i.drv.selectN <= 1'b0;
    tick(6);
    chk("dataOeN", 0, dataOeN);
    for (int i = 0; i < 3; i++) begin
      cfpd_host_i.byte_clk(8'h00, q);
      chk("readback", 8'h21 + 8'(i) * 8'h11, q);
    end
    cfpd_host_i.drv.selectN <= 1'b1;
    tick(6);
    chk("dataOeN", 1, dataOeN);
    cfpd_host_i.drv.readReq <= 1'b0;
    cfpd_host_i.drv.selectN <= 1'b0;
    tick(6);
    chk("dataOeN", 1, dataOeN);
    // Test-port mode: refresh clears, then instructions set the flags
    cfpd_host_i.drv.selectN <= 1'b1;
    cfpd_host_i.drv.portModeSel <= 1'b1;
    tick(6);
    cfpd_host_i.drv.progReqN <= 1'b0;
    tick(8);
    cfpd_host_i.drv.progReqN <= 1'b1;
    tick(8);
    chk("volatileComplete", 0, volatileComplete);
    repeat (5) cfpd_host_i.tap_clk(1'b1, 1'b1);
    cfpd_host_i.tap_clk(1'b0, 1'b1);
    tap_ir(IR_ISC_DISABLE_CODE);
    chk("volatileComplete", 1, volatileComplete);
    nvTarget <= 1'b1;
    tap_ir(IR_ISC_DISABLE_CODE);
    chk("nonvolatileComplete", 0, nonvolatileComplete);
    nvProgVerified <= 1'b1;
    tap_ir(IR_ISC_DISABLE_CODE);
    chk("nonvolatileComplete", 1, nonvolatileComplete);
    cfpd_host_i.drv.progReqN <= 1'b0;
    tick(8);
    chk("doneOeN", 0, doneOeN);
    cfpd_host_i.drv.progReqN <= 1'b1;
    tick(8);
    chk("volatileComplete", 1, volatileComplete);
    finish_test();
  end
endmodule : cfpd_config_port_bench
